// ---- logic/gdm_pkg.sv ----
// Contract
// - seven monitors drive flags, low means fault
// - status read command returns status register
// - stretch any low pulse to 1.5-2.0 ms
// - bit 7 converter overflow, recoverable
// - bit 6 arithmetic overflow, not recoverable
// - bit 5 calibration parity fail, not recoverable
// - bit 4 analog test, never substitutes rate
// - bit 3 supply out of range, not recoverable
// - bit 2 electrode open or leaky, not recoverable
// - bit 1 excitation lock lost, recoverable
// - bit 0 unused, reads one
// - rate reads give error code before start-up
// - start-up done at first excitation lock rise
// - rate readable after start-up, even unsettled
// - fault after start-up substitutes code, holds processing
// - fault persists; recoverable cleared by recovery command
// - recovery needs all three guard disables first
// - no fault latching while guard disabled
//
// package of the diagnostic status monitor: constants, types, encodings.
// assumes a 25 MHz core clock and a command link on its own clock.
`default_nettype none

package gdm_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_KHZ        = 25000;
    localparam int unsigned STRETCH_MIN_US = 1500;
    localparam int unsigned STRETCH_CYC    = (STRETCH_MIN_US * CLK_KHZ + 999) / 1000;

    // ------------------------------------------------------------
    // status register layout
    // ------------------------------------------------------------
    localparam int unsigned BIT_ADC    = 7;
    localparam int unsigned BIT_ARITH  = 6;
    localparam int unsigned BIT_CALIB  = 5;
    localparam int unsigned BIT_ATEST  = 4;
    localparam int unsigned BIT_SUPPLY = 3;
    localparam int unsigned BIT_ELEC   = 2;
    localparam int unsigned BIT_EXC    = 1;
    localparam int unsigned BIT_UNUSED = 0;

    localparam logic [7:0] FLAGS_RST     = 8'h01;
    localparam logic [7:0] FAULT_MASK    = 8'hEE;
    localparam logic [7:0] RECOVER_MASK  = 8'h82;
    localparam logic [7:0] FAULTS_RST    = 8'h00;
    localparam logic [7:0] RSP_RST       = 8'h00;
    localparam logic [7:0] ACK_BYTE      = 8'h00;
    localparam logic [15:0] ERROR_CODE   = 16'h8000;

    typedef struct packed {
        logic conv_in_range;
        logic arith_healthy;
        logic calib_parity_good;
        logic analog_test_off;
        logic supply_in_range;
        logic electrode_healthy;
        logic excitation_locked;
        logic unused_one;
    } gdm_flags_t;

    // ------------------------------------------------------------
    // commands and guard sequence
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_STATUS_READ = 4'h1,
        CMD_RATE_HIGH   = 4'h2,
        CMD_RATE_LOW    = 4'h3,
        CMD_GUARD_DIS1  = 4'h4,
        CMD_GUARD_DIS2  = 4'h5,
        CMD_GUARD_DIS3  = 4'h6,
        CMD_RECOVER     = 4'h7,
        CMD_GUARD_EN    = 4'h8
    } gdm_cmd_t;

    localparam gdm_cmd_t CMD_RST = CMD_STATUS_READ;

    typedef enum logic [3:0] {
        GUARD_ARMED = 4'b0001,
        GUARD_DIS1  = 4'b0010,
        GUARD_DIS2  = 4'b0100,
        GUARD_OFF   = 4'b1000
    } gdm_guard_t;

endpackage

`default_nettype wire

// ---- logic/gdm_monitor.sv ----
// diagnostic status monitor: flag stretching, fault latch, guarded recovery,
// rate substitution and the command link crossing.
// assumes monitor inputs are asynchronous levels and the rate sample
// comes from logic on ref_clk_i; the link clock runs through each exchange.
`timescale 1ns/1ps
`default_nettype none

module gdm_monitor #(
    parameter int unsigned STRETCH_CYCLES = gdm_pkg::STRETCH_CYC
) (
    input  wire logic             ref_clk_i,
    input  wire logic             nrst_i,
    input  wire logic [7:1]       monitor_ok_i,
    input  wire logic [15:0]      rate_sample_i,
    input  wire logic             link_clk_i,
    input  wire logic             cmd_valid_i,
    input  wire gdm_pkg::gdm_cmd_t cmd_code_i,
    output logic                  cmd_busy_o,
    output logic                  rsp_valid_o,
    output logic [7:0]            rsp_data_o,
    output gdm_pkg::gdm_flags_t   health_flags_o,
    output logic                  startup_done_o,
    output logic                  dsp_hold_o
);

    localparam int unsigned CW = $clog2(STRETCH_CYCLES + 1);
    localparam logic [CW-1:0] STRETCH_LOAD = CW'(STRETCH_CYCLES);
    localparam logic [CW-1:0] CNT_ZERO     = '0;

    // ------------------------------------------------------------
    // monitor input synchronisers
    // ------------------------------------------------------------
    logic [7:1] mon_s1_q;
    logic [7:1] mon_s2_q;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mon_s1_q <= '0;
            mon_s2_q <= '0;
        end else begin
            mon_s1_q <= monitor_ok_i;
            mon_s2_q <= mon_s1_q;
        end
    end

    // ------------------------------------------------------------
    // pulse stretching, one counter per monitor flag (bits 7 to 1); bit 0 is tied high
    // ------------------------------------------------------------
    // the counter reloads on every low sample, so a flag stays low at
    // least the full stretch after its monitor recovers
    wire logic [7:0] flags_q;
    assign flags_q[gdm_pkg::BIT_UNUSED] = 1'b1;

    genvar gi;
    generate
        for (gi = 1; gi < 8; gi++) begin : g_stretch
            logic [CW-1:0] cnt_q;
            logic          flag_q;

            always_ff @(posedge ref_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    cnt_q <= CNT_ZERO;
                end else if (!mon_s2_q[gi]) begin
                    cnt_q <= STRETCH_LOAD;
                end else if (cnt_q != CNT_ZERO) begin
                    cnt_q <= cnt_q - CW'(1);
                end
            end

            always_ff @(posedge ref_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    flag_q <= gdm_pkg::FLAGS_RST[gi];
                end else begin
                    flag_q <= mon_s2_q[gi] && (cnt_q == CNT_ZERO);
                end
            end

            assign flags_q[gi] = flag_q;
        end
    endgenerate

    // ------------------------------------------------------------
    // start-up detection
    // ------------------------------------------------------------
    logic started_q;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            started_q <= 1'b0;
        end else if (flags_q[gdm_pkg::BIT_EXC]) begin
            started_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // command arrival from the link domain
    // ------------------------------------------------------------
    logic              lk_req_tgl_q;
    gdm_pkg::gdm_cmd_t lk_cmd_q;
    logic              req_s1_q;
    logic              req_s2_q;
    logic              req_s3_q;
    logic              new_cmd;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
        end else begin
            req_s1_q <= lk_req_tgl_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
        end
    end

    // lk_cmd_q is held by the link side until the answer returns
    assign new_cmd = req_s2_q ^ req_s3_q;

    // ------------------------------------------------------------
    // safeguard sequence
    // ------------------------------------------------------------
    gdm_pkg::gdm_guard_t guard_q;
    logic                recover_ok;

    // an out-of-order disable restarts the sequence from the start
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            guard_q <= gdm_pkg::GUARD_ARMED;
        end else if (new_cmd) begin
            unique case (lk_cmd_q)
                gdm_pkg::CMD_GUARD_DIS1: begin
                    if (guard_q != gdm_pkg::GUARD_OFF) begin
                        guard_q <= gdm_pkg::GUARD_DIS1;
                    end
                end
                gdm_pkg::CMD_GUARD_DIS2: begin
                    if (guard_q == gdm_pkg::GUARD_DIS1) begin
                        guard_q <= gdm_pkg::GUARD_DIS2;
                    end else if (guard_q != gdm_pkg::GUARD_OFF) begin
                        guard_q <= gdm_pkg::GUARD_ARMED;
                    end
                end
                gdm_pkg::CMD_GUARD_DIS3: begin
                    if (guard_q == gdm_pkg::GUARD_DIS2) begin
                        guard_q <= gdm_pkg::GUARD_OFF;
                    end else if (guard_q != gdm_pkg::GUARD_OFF) begin
                        guard_q <= gdm_pkg::GUARD_ARMED;
                    end
                end
                gdm_pkg::CMD_GUARD_EN: begin
                    guard_q <= gdm_pkg::GUARD_ARMED;
                end
                default: begin
                    guard_q <= guard_q;
                end
            endcase
        end
    end

    assign recover_ok = new_cmd && (lk_cmd_q == gdm_pkg::CMD_RECOVER)
                        && (guard_q == gdm_pkg::GUARD_OFF);

    // ------------------------------------------------------------
    // fault latch
    // ------------------------------------------------------------
    // analog test (bit 4) is outside the mask; bit 0 never faults
    logic [7:0] faults_q;
    logic [7:0] fault_set;

    always_comb begin
        fault_set = '0;
        if (started_q && (guard_q != gdm_pkg::GUARD_OFF)) begin
            fault_set = ~flags_q & gdm_pkg::FAULT_MASK;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            faults_q <= gdm_pkg::FAULTS_RST;
        end else if (recover_ok) begin
            faults_q <= (faults_q & ~gdm_pkg::RECOVER_MASK) | fault_set;
        end else begin
            faults_q <= faults_q | fault_set;
        end
    end

    // ------------------------------------------------------------
    // rate substitution and answers
    // ------------------------------------------------------------
    logic       subst_err;
    logic [7:0] rsp_byte_q;
    logic       ack_tgl_q;

    assign subst_err = !started_q || (faults_q != gdm_pkg::FAULTS_RST);

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rsp_byte_q <= gdm_pkg::RSP_RST;
        end else if (new_cmd) begin
            unique case (lk_cmd_q)
                gdm_pkg::CMD_STATUS_READ: begin
                    rsp_byte_q <= flags_q;
                end
                gdm_pkg::CMD_RATE_HIGH: begin
                    rsp_byte_q <= subst_err ? gdm_pkg::ERROR_CODE[15:8]
                                            : rate_sample_i[15:8];
                end
                gdm_pkg::CMD_RATE_LOW: begin
                    rsp_byte_q <= subst_err ? gdm_pkg::ERROR_CODE[7:0]
                                            : rate_sample_i[7:0];
                end
                default: begin
                    rsp_byte_q <= gdm_pkg::ACK_BYTE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_tgl_q <= 1'b0;
        end else if (new_cmd) begin
            ack_tgl_q <= ~ack_tgl_q;
        end
    end

    // ------------------------------------------------------------
    // core-side outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            health_flags_o <= gdm_pkg::FLAGS_RST;
            startup_done_o <= 1'b0;
            dsp_hold_o     <= 1'b0;
        end else begin
            health_flags_o <= flags_q;
            startup_done_o <= started_q;
            dsp_hold_o     <= started_q && (faults_q != gdm_pkg::FAULTS_RST);
        end
    end

    // ------------------------------------------------------------
    // link domain: command capture and answer return
    // ------------------------------------------------------------
    // one exchange at a time; a command while busy is dropped, since
    // overwriting lk_cmd_q would corrupt the crossing
    logic lk_ack_s1_q;
    logic lk_ack_s2_q;
    logic lk_ack_s3_q;
    logic lk_ack_edge;

    assign lk_ack_edge = lk_ack_s2_q ^ lk_ack_s3_q;

    always_ff @(posedge link_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lk_ack_s1_q <= 1'b0;
            lk_ack_s2_q <= 1'b0;
            lk_ack_s3_q <= 1'b0;
        end else begin
            lk_ack_s1_q <= ack_tgl_q;
            lk_ack_s2_q <= lk_ack_s1_q;
            lk_ack_s3_q <= lk_ack_s2_q;
        end
    end

    always_ff @(posedge link_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lk_req_tgl_q <= 1'b0;
            lk_cmd_q     <= gdm_pkg::CMD_RST;
        end else if (cmd_valid_i && !cmd_busy_o) begin
            lk_req_tgl_q <= ~lk_req_tgl_q;
            lk_cmd_q     <= cmd_code_i;
        end
    end

    always_ff @(posedge link_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cmd_busy_o <= 1'b0;
        end else if (cmd_valid_i && !cmd_busy_o) begin
            cmd_busy_o <= 1'b1;
        end else if (lk_ack_edge) begin
            cmd_busy_o <= 1'b0;
        end
    end

    // rsp_byte_q is stable from the ack toggle until the next command
    always_ff @(posedge link_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o  <= gdm_pkg::RSP_RST;
        end else begin
            rsp_valid_o <= lk_ack_edge;
            if (lk_ack_edge) begin
                rsp_data_o <= rsp_byte_q;
            end
        end
    end

endmodule

`default_nettype wire

// ---- tb/gdm_monitor_sva.sv ----
// ------------------------------------------------------------
// checker of the diagnostic status monitor
// ------------------------------------------------------------
// assumes it is bound onto gdm_monitor; both domains share nrst_i
`timescale 1ns/1ps
`default_nettype none

module gdm_monitor_sva #(
    parameter int unsigned STRETCH_CYCLES = gdm_pkg::STRETCH_CYC
) (
    input wire logic                ref_clk_i,
    input wire logic                nrst_i,
    input wire logic [7:1]          monitor_ok_i,
    input wire logic                link_clk_i,
    input wire logic                cmd_valid_i,
    input wire gdm_pkg::gdm_cmd_t   cmd_code_i,
    input wire logic                cmd_busy_o,
    input wire logic                rsp_valid_o,
    input wire gdm_pkg::gdm_flags_t health_flags_o,
    input wire logic                startup_done_o,
    input wire logic                dsp_hold_o
);
    // low-run length of the converter flag; saturating, and preset so lows left by reset pass
    int unsigned lo_q;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lo_q <= STRETCH_CYCLES;
        end else if (health_flags_o[7]) begin
            lo_q <= 0;
        end else if (lo_q < STRETCH_CYCLES) begin
            lo_q <= lo_q + 1;
        end
    end

    // guard may be off from the first disable taken until the enable is answered;
    // latching is not expected then, so the hold checks stand aside
    gdm_pkg::gdm_cmd_t last_cmd_q;
    logic              guard_open_q;
    logic              guard_s1_q;
    logic              guard_s2_q;
    logic              nr_fault_q;
    always_ff @(posedge link_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            last_cmd_q   <= gdm_pkg::CMD_RST;
            guard_open_q <= 1'b0;
        end else begin
            if (cmd_valid_i && !cmd_busy_o) begin
                last_cmd_q <= cmd_code_i;
            end
            if (cmd_valid_i && !cmd_busy_o && (cmd_code_i >= gdm_pkg::CMD_GUARD_DIS1)
                && (cmd_code_i <= gdm_pkg::CMD_GUARD_DIS3)) begin
                guard_open_q <= 1'b1;
            end else if (rsp_valid_o && (last_cmd_q == gdm_pkg::CMD_GUARD_EN)) begin
                guard_open_q <= 1'b0;
            end
        end
    end
    // a non-recoverable fault seen with the guard closed must keep the hold for good
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            guard_s1_q <= 1'b0;
            guard_s2_q <= 1'b0;
            nr_fault_q <= 1'b0;
        end else begin
            guard_s1_q <= guard_open_q;
            guard_s2_q <= guard_s1_q;
            if (startup_done_o && !guard_s2_q
                && !(&{health_flags_o[6:5], health_flags_o[3:2]})) begin
                nr_fault_q <= 1'b1;
            end
        end
    end

    property p_bit0;
        @(posedge ref_clk_i) disable iff (!nrst_i) health_flags_o[0];
    endproperty
    a_bit0: assert property (p_bit0) else $error("unused bit not one");
    property p_adc_low;
        @(posedge ref_clk_i) disable iff (!nrst_i) $fell(monitor_ok_i[7]) |-> ##4 !health_flags_o[7];
    endproperty
    a_adc_low: assert property (p_adc_low) else $error("fault not shown");
    property p_stretch;
        @(posedge ref_clk_i) disable iff (!nrst_i)
            $rose(health_flags_o[7]) |-> lo_q >= STRETCH_CYCLES;
    endproperty
    a_stretch: assert property (p_stretch) else $error("low pulse too short");
    property p_start;
        @(posedge ref_clk_i) disable iff (!nrst_i)
            $rose(startup_done_o) |-> health_flags_o[1] || $past(health_flags_o[1]);
    endproperty
    a_start: assert property (p_start) else $error("start without lock");
    property p_no_early_hold;
        @(posedge ref_clk_i) disable iff (!nrst_i) !startup_done_o |-> !dsp_hold_o;
    endproperty
    a_no_early_hold: assert property (p_no_early_hold) else $error("early hold");
    property p_hold;
        @(posedge ref_clk_i) disable iff (!nrst_i)
            startup_done_o && !guard_s2_q && !health_flags_o[6] |-> ##[0:4] dsp_hold_o;
    endproperty
    a_hold: assert property (p_hold) else $error("fault not held");
    property p_hold_free;
        @(posedge ref_clk_i) disable iff (!nrst_i)
            $fell(dsp_hold_o) |-> !nr_fault_q;
    endproperty
    a_hold_free: assert property (p_hold_free) else $error("hold freed early");
    property p_accept;
        @(posedge link_clk_i) disable iff (!nrst_i) cmd_valid_i && !cmd_busy_o |=> cmd_busy_o;
    endproperty
    a_accept: assert property (p_accept) else $error("command not taken");
    property p_answer;
        @(posedge link_clk_i) disable iff (!nrst_i) $rose(cmd_busy_o) |-> ##[1:12] rsp_valid_o;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
endmodule

bind gdm_monitor gdm_monitor_sva #(.STRETCH_CYCLES(STRETCH_CYCLES)) gdm_monitor_sva_inst (
    .ref_clk_i, .nrst_i, .monitor_ok_i, .link_clk_i, .cmd_valid_i, .cmd_code_i, .cmd_busy_o,
    .rsp_valid_o, .health_flags_o, .startup_done_o, .dsp_hold_o);

`default_nettype wire

// ---- tb/gdm_host.sv ----
// ------------------------------------------------------------
// host model issuing link commands
// ------------------------------------------------------------
// assumes a free-running link clock and one command outstanding
`timescale 1ns/1ps
`default_nettype none

module gdm_host (
    input  wire logic             link_clk_i,
    input  wire logic             cmd_busy_i,
    input  wire logic             rsp_valid_i,
    input  wire logic [7:0]       rsp_data_i,
    output var logic              cmd_valid_o,
    output var gdm_pkg::gdm_cmd_t cmd_code_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_code_o  = gdm_pkg::CMD_STATUS_READ;
    end

    task automatic xfer(input gdm_pkg::gdm_cmd_t c, output logic [7:0] d);
        int n;
        d = 8'hXX;
        @(posedge link_clk_i);
        while (cmd_busy_i) @(posedge link_clk_i);
        cmd_valid_o <= 1'b1;
        cmd_code_o  <= c;
        @(posedge link_clk_i);
        cmd_valid_o <= 1'b0;
        // scrambled after release so a stale code passes for a command only after CMD_RECOVER or CMD_GUARD_EN, each turning into the other
        cmd_code_o  <= gdm_pkg::gdm_cmd_t'(~c);
        for (n = 0; n < 20 && !rsp_valid_i; n++) @(posedge link_clk_i);
        if (rsp_valid_i) d = rsp_data_i;
    endtask
endmodule

`default_nettype wire

// ---- tb/gdm_monitor_bench.sv ----
// ------------------------------------------------------------
// testbench of the diagnostic status monitor
// ------------------------------------------------------------
// assumes gdm_pkg, gdm_host and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none

module gdm_monitor_bench;
    localparam int unsigned STRETCH = 20;
    logic                ref_clk, link_clk, nrst, cmd_valid, busy, rsp_valid, started, hold;
    logic [7:1]          mon;
    logic [15:0]         rate;
    logic [7:0]          rsp_data;
    gdm_pkg::gdm_cmd_t   cmd_code;
    gdm_pkg::gdm_flags_t flags;
    int                  miscompares, cmp_count, b;

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #80 link_clk = ~link_clk;
    end

    gdm_monitor #(.STRETCH_CYCLES(STRETCH)) gdm_monitor_inst (
        .ref_clk_i(ref_clk), .nrst_i(nrst), .monitor_ok_i(mon), .rate_sample_i(rate),
        .link_clk_i(link_clk), .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code),
        .cmd_busy_o(busy), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
        .health_flags_o(flags), .startup_done_o(started), .dsp_hold_o(hold));
    gdm_host gdm_host_inst (
        .link_clk_i(link_clk), .cmd_busy_i(busy), .rsp_valid_i(rsp_valid),
        .rsp_data_i(rsp_data), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input gdm_pkg::gdm_cmd_t c, input logic [7:0] exp);
        logic [7:0] d;
        gdm_host_inst.xfer(c, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask
    task automatic rate_chk(input logic [15:0] exp);
        rd(gdm_pkg::CMD_RATE_HIGH, exp[15:8]);
        rd(gdm_pkg::CMD_RATE_LOW, exp[7:0]);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic pulse(input int k);
        wt(1);
        mon[k] <= 1'b0;
        wt(1);
        mon[k] <= 1'b1;
    endtask
    // host side of recovery: no recoverable fault showing, then the settling gap,
    // scaled like the stretch (twenty stretches), before the guard sequence
    task automatic guard_off;
        rd(gdm_pkg::CMD_STATUS_READ, 8'hFF);
        wt(20 * STRETCH);
        rd(gdm_pkg::CMD_GUARD_DIS1, gdm_pkg::ACK_BYTE);
        rd(gdm_pkg::CMD_GUARD_DIS2, gdm_pkg::ACK_BYTE);
        rd(gdm_pkg::CMD_GUARD_DIS3, gdm_pkg::ACK_BYTE);
        rd(gdm_pkg::CMD_RECOVER, gdm_pkg::ACK_BYTE);
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // whole sequence needs about 100 us; four times that means a hang
    initial begin
        #400_000;
        miscompares++;
        end_of_test();
    end

    initial begin
        nrst = 1'b0;
        mon = 7'h7E;
        rate = 16'h1234;
        miscompares = 0;
        cmp_count = 0;
        wt(10);
        nrst <= 1'b1;
        wt(2 * STRETCH);
        rate_chk(gdm_pkg::ERROR_CODE);
        rd(gdm_pkg::CMD_STATUS_READ, 8'hFD);
        for (b = 2; b < 8; b++) begin
            wt(1);
            mon[b] <= 1'b0;
            wt(8);
            rd(gdm_pkg::CMD_STATUS_READ, 8'hFD & ~(8'h01 << b));
            wt(1);
            mon[b] <= 1'b1;
            wt(2 * STRETCH);
        end
        $display("test 1 done");
        wt(1);
        mon[1] <= 1'b1;
        wt(2 * STRETCH);
        chk({15'h0000, started}, 16'h0001);
        rd(gdm_pkg::CMD_STATUS_READ, 8'hFF);
        rate_chk(16'h1234);
        wt(1);
        mon[4] <= 1'b0;
        wt(8);
        rd(gdm_pkg::CMD_STATUS_READ, 8'hEF);
        rate_chk(16'h1234);
        wt(1);
        mon[4] <= 1'b1;
        wt(2 * STRETCH);
        $display("test 2 done");
        pulse(7);
        wt(8);
        chk({8'h00, flags}, 16'h007F);
        chk({15'h0000, hold}, 16'h0001);
        rate_chk(gdm_pkg::ERROR_CODE);
        pulse(1);
        wt(8);
        chk({8'h00, flags}, 16'h00FD);
        wt(2 * STRETCH);
        rd(gdm_pkg::CMD_STATUS_READ, 8'hFF);
        rate_chk(gdm_pkg::ERROR_CODE);
        $display("test 3 done");
        rd(gdm_pkg::CMD_RECOVER, gdm_pkg::ACK_BYTE);
        rd(gdm_pkg::CMD_GUARD_DIS1, gdm_pkg::ACK_BYTE);
        rd(gdm_pkg::CMD_GUARD_DIS2, gdm_pkg::ACK_BYTE);
        rd(gdm_pkg::CMD_RECOVER, gdm_pkg::ACK_BYTE);
        rate_chk(gdm_pkg::ERROR_CODE);
        $display("test 4 done");
        guard_off();
        rate_chk(16'h1234);
        pulse(7);
        wt(2 * STRETCH);
        rd(gdm_pkg::CMD_GUARD_EN, gdm_pkg::ACK_BYTE);
        rate_chk(16'h1234);
        chk({15'h0000, hold}, 16'h0000);
        $display("test 5 done");
        pulse(6);
        wt(8);
        chk({15'h0000, hold}, 16'h0001);
        wt(2 * STRETCH);
        guard_off();
        rd(gdm_pkg::CMD_GUARD_EN, gdm_pkg::ACK_BYTE);
        rate_chk(gdm_pkg::ERROR_CODE);
        $display("test 6 done");
        end_of_test();
    end
endmodule

`default_nettype wire
